// *** include/jtbi_defs.svh ***
`ifndef JTBI_DEFS_SVH
`define JTBI_DEFS_SVH

// ------------------------------------------------------------
// Instruction register
// ------------------------------------------------------------
`define JTBI_IR_W 6
`define JTBI_OP_IDCODE 6'h02
`define JTBI_OP_VALIDATE 6'h2d
`define JTBI_OP_CLAMP 6'h3e
`define JTBI_OP_BYPASS 6'h3f
`define JTBI_RSV_A_LO 6'h04
`define JTBI_RSV_A_HI 6'h2c
`define JTBI_RSV_B_LO 6'h2e
`define JTBI_RSV_B_HI 6'h3d

// ------------------------------------------------------------
// Identification register layout
// ------------------------------------------------------------
`define JTBI_ID_W 32
`define JTBI_ID_LSB_VAL 1'b1
`define JTBI_MAKER_W 11
`define JTBI_PART_W 16
`define JTBI_REV_W 4

// ------------------------------------------------------------
// Reset and capture values
// ------------------------------------------------------------
`define JTBI_BYPASS_CAPTURE 1'b0
`define JTBI_PINS_RST 4'h0
`define JTBI_TMS_CNT_W 3
`define JTBI_TMS_RESET_CNT 3'h5

`endif

// *** include/jtbi_pkg.sv ***
`default_nettype none

package jtbi_pkg;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } jtbi_state_t;

    // ------------------------------------------------------------
    // Test pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trstN;
    } jtbi_pins_t;

endpackage : jtbi_pkg

`default_nettype wire

// *** rtl/jtbi_sync.sv ***
`include "jtbi_defs.svh"
`default_nettype none

module jtbi_sync (
    input wire logic clk,
    input wire logic rst,
    input wire jtbi_pkg::jtbi_pins_t pinsAsync,
    output jtbi_pkg::jtbi_pins_t pinsSync
);

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    jtbi_pkg::jtbi_pins_t stage1Reg;
    jtbi_pkg::jtbi_pins_t stage1Next;
    jtbi_pkg::jtbi_pins_t stage2Reg;
    jtbi_pkg::jtbi_pins_t stage2Next;

    always_comb begin
        stage1Next = pinsAsync;
        stage2Next = stage1Reg;
    end

    // Test reset reads asserted while the chip is in reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1Reg <= `JTBI_PINS_RST;
            stage2Reg <= `JTBI_PINS_RST;
        end else begin
            stage1Reg <= stage1Next;
            stage2Reg <= stage2Next;
        end
    end

    assign pinsSync = stage2Reg;

endmodule : jtbi_sync

`default_nettype wire

// *** rtl/jtbi_tap.sv ***
// What this block does
// RL1: Bypass instruction puts one flip-flop between TDI and TDO.
// RL2: Capture-DR with bypass selected loads zero into bypass flip-flop.
// RL3: Clamp holds boundary outputs fixed and routes serial path through bypass.
// RL4: Test reset or five TMS-high clocks make identification current.
// RL5: Identification value bit zero is always one.
// RL6: Tester may read first bit one as identification, zero as bypass.
// RL7: Bypass exists too, but is not the default after reset.
// RL8: Identification instruction plus Shift-DR shifts out the 32-bit value.
// RL9: Maker code bits 11:1, part code bits 27:12, bit 0 one.
// RL10: Bits 31:28 hold a read-only 4-bit revision code.
// RL11: Capture-IR loads the validate pattern, low bits 01.
// RL12: Tester must not load reserved opcodes.
// RL13: Tester should hold the controller in reset in normal operation.
// RL14: Six-bit decode of identification, clamp, bypass and reserved codes.
// RL15: Instruction bits shift on rising TCK, become current at Update-IR.
// RL16: Sixteen-state controller, TMS on rising TCK, TDO on falling TCK.
`include "jtbi_defs.svh"
`default_nettype none

module jtbi_tap #(
    // Arbitrary value
    parameter logic [`JTBI_MAKER_W-1:0] MAKER_CODE_FIELD = 11'h155,
    // Arbitrary value
    parameter logic [`JTBI_PART_W-1:0] PART_CODE = 16'h1234,
    // Arbitrary value
    parameter logic [`JTBI_REV_W-1:0] REVISION_CODE = 4'h1
) (
    input wire logic clk,
    input wire logic rst,
    input wire jtbi_pkg::jtbi_pins_t pinsIn,
    output logic tdo,
    output logic tdoOe,
    output logic clampActive,
    output logic testModeActive,
    output logic [`JTBI_IR_W-1:0] instrCurrent
);

    // ------------------------------------------------------------
    // Identification value
    // ------------------------------------------------------------
    // RL9 field packing
    // RL10 revision field
    localparam logic [`JTBI_ID_W-1:0] ID_VALUE =
        {REVISION_CODE, PART_CODE, MAKER_CODE_FIELD, `JTBI_ID_LSB_VAL};

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // RL16 controller transitions
    function automatic jtbi_pkg::jtbi_state_t tapNext(
        input jtbi_pkg::jtbi_state_t s,
        input logic tms
    );
        jtbi_pkg::jtbi_state_t n;
        n = s;
        unique case (s)
            jtbi_pkg::TEST_LOGIC_RESET: n = tms ? jtbi_pkg::TEST_LOGIC_RESET : jtbi_pkg::RUN_TEST_IDLE;
            jtbi_pkg::RUN_TEST_IDLE: n = tms ? jtbi_pkg::SELECT_DR : jtbi_pkg::RUN_TEST_IDLE;
            jtbi_pkg::SELECT_DR: n = tms ? jtbi_pkg::SELECT_IR : jtbi_pkg::CAPTURE_DR;
            jtbi_pkg::CAPTURE_DR: n = tms ? jtbi_pkg::EXIT1_DR : jtbi_pkg::SHIFT_DR;
            jtbi_pkg::SHIFT_DR: n = tms ? jtbi_pkg::EXIT1_DR : jtbi_pkg::SHIFT_DR;
            jtbi_pkg::EXIT1_DR: n = tms ? jtbi_pkg::UPDATE_DR : jtbi_pkg::PAUSE_DR;
            jtbi_pkg::PAUSE_DR: n = tms ? jtbi_pkg::EXIT2_DR : jtbi_pkg::PAUSE_DR;
            jtbi_pkg::EXIT2_DR: n = tms ? jtbi_pkg::UPDATE_DR : jtbi_pkg::SHIFT_DR;
            jtbi_pkg::UPDATE_DR: n = tms ? jtbi_pkg::SELECT_DR : jtbi_pkg::RUN_TEST_IDLE;
            jtbi_pkg::SELECT_IR: n = tms ? jtbi_pkg::TEST_LOGIC_RESET : jtbi_pkg::CAPTURE_IR;
            jtbi_pkg::CAPTURE_IR: n = tms ? jtbi_pkg::EXIT1_IR : jtbi_pkg::SHIFT_IR;
            jtbi_pkg::SHIFT_IR: n = tms ? jtbi_pkg::EXIT1_IR : jtbi_pkg::SHIFT_IR;
            jtbi_pkg::EXIT1_IR: n = tms ? jtbi_pkg::UPDATE_IR : jtbi_pkg::PAUSE_IR;
            jtbi_pkg::PAUSE_IR: n = tms ? jtbi_pkg::EXIT2_IR : jtbi_pkg::PAUSE_IR;
            jtbi_pkg::EXIT2_IR: n = tms ? jtbi_pkg::UPDATE_IR : jtbi_pkg::SHIFT_IR;
            jtbi_pkg::UPDATE_IR: n = tms ? jtbi_pkg::SELECT_DR : jtbi_pkg::RUN_TEST_IDLE;
        endcase
        return n;
    endfunction : tapNext

    // RL14 identification decode; every other code uses bypass
    function automatic logic isIdSel(input logic [`JTBI_IR_W-1:0] ir);
        return ir == `JTBI_OP_IDCODE;
    endfunction : isIdSel

    // RL14 reserved ranges
    function automatic logic isReserved(input logic [`JTBI_IR_W-1:0] ir);
        return ((ir >= `JTBI_RSV_A_LO) && (ir <= `JTBI_RSV_A_HI)) ||
               ((ir >= `JTBI_RSV_B_LO) && (ir <= `JTBI_RSV_B_HI));
    endfunction : isReserved

    // ------------------------------------------------------------
    // Pin synchroniser and edges
    // ------------------------------------------------------------
    jtbi_pkg::jtbi_pins_t pins;

    jtbi_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pinsAsync(pinsIn),
        .pinsSync(pins)
    );

    jtbi_pkg::jtbi_state_t stateReg;
    jtbi_pkg::jtbi_state_t stateNext;
    logic [`JTBI_IR_W-1:0] irShiftReg;
    logic [`JTBI_IR_W-1:0] irShiftNext;
    logic [`JTBI_IR_W-1:0] irReg;
    logic [`JTBI_IR_W-1:0] irNext;
    logic bypassReg;
    logic bypassNext;
    logic [`JTBI_ID_W-1:0] idShiftReg;
    logic [`JTBI_ID_W-1:0] idShiftNext;
    logic tdoReg;
    logic tdoNext;
    logic tdoOeReg;
    logic tdoOeNext;
    logic clampReg;
    logic clampNext;
    logic testModeReg;
    logic testModeNext;
    logic tckPrevReg;
    logic tckPrevNext;
    logic [`JTBI_TMS_CNT_W-1:0] tmsCntReg;
    logic [`JTBI_TMS_CNT_W-1:0] tmsCntNext;
    logic tckRise;
    logic tckFall;
    logic idSel;

    // Edge found a few clocks late; fine at the slow test clock
    assign tckRise = pins.tck & ~tckPrevReg;
    assign tckFall = ~pins.tck & tckPrevReg;
    assign idSel = isIdSel(irReg);

    // ------------------------------------------------------------
    // Controller and registers
    // ------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        irShiftNext = irShiftReg;
        irNext = irReg;
        bypassNext = bypassReg;
        idShiftNext = idShiftReg;
        tdoNext = tdoReg;
        tdoOeNext = tdoOeReg;
        tckPrevNext = pins.tck;
        tmsCntNext = tmsCntReg;
        if (!pins.trstN) begin
            // RL4 test reset
            stateNext = jtbi_pkg::TEST_LOGIC_RESET;
            irNext = `JTBI_OP_IDCODE;
            tdoOeNext = 1'b0;
            tmsCntNext = '0;
        end else begin
            if (tckRise) begin
                if (!pins.tms) begin
                    tmsCntNext = '0;
                end else if (tmsCntReg != `JTBI_TMS_RESET_CNT) begin
                    tmsCntNext = tmsCntReg + `JTBI_TMS_CNT_W'(1);
                end
                // RL11 validate capture
                if (stateReg == jtbi_pkg::CAPTURE_IR) begin
                    irShiftNext = `JTBI_OP_VALIDATE;
                end
                // RL15 instruction shift
                if (stateReg == jtbi_pkg::SHIFT_IR) begin
                    irShiftNext = {pins.tdi, irShiftReg[`JTBI_IR_W-1:1]};
                end
                if (stateReg == jtbi_pkg::CAPTURE_DR) begin
                    if (idSel) begin
                        // RL5 fixed one in bit zero
                        idShiftNext = ID_VALUE;
                    end else begin
                        // RL2 bypass capture zero
                        bypassNext = `JTBI_BYPASS_CAPTURE;
                    end
                end
                if (stateReg == jtbi_pkg::SHIFT_DR) begin
                    if (idSel) begin
                        // RL8 identification shift
                        idShiftNext = {pins.tdi, idShiftReg[`JTBI_ID_W-1:1]};
                    end else begin
                        // RL1 one-bit path
                        bypassNext = pins.tdi;
                    end
                end
                // RL16 TMS on rising edge
                stateNext = tapNext(stateReg, pins.tms);
            end
            if (tckFall) begin
                // RL15 update makes current
                if (stateReg == jtbi_pkg::UPDATE_IR) begin
                    irNext = irShiftReg;
                end
                // RL16 TDO on falling edge
                tdoOeNext = (stateReg == jtbi_pkg::SHIFT_IR) || (stateReg == jtbi_pkg::SHIFT_DR);
                if (stateReg == jtbi_pkg::SHIFT_IR) begin
                    tdoNext = irShiftReg[0];
                end else if (stateReg == jtbi_pkg::SHIFT_DR) begin
                    tdoNext = idSel ? idShiftReg[0] : bypassReg;
                end else begin
                    tdoNext = 1'b0;
                end
            end
            // RL7 identification by default
            if (stateReg == jtbi_pkg::TEST_LOGIC_RESET) begin
                irNext = `JTBI_OP_IDCODE;
            end
        end
        // RL3 clamp outputs
        clampNext = irNext == `JTBI_OP_CLAMP;
        testModeNext = isReserved(irNext);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stateReg <= jtbi_pkg::TEST_LOGIC_RESET;
            irShiftReg <= '0;
            irReg <= `JTBI_OP_IDCODE;
            bypassReg <= `JTBI_BYPASS_CAPTURE;
            idShiftReg <= '0;
            tdoReg <= 1'b0;
            tdoOeReg <= 1'b0;
            clampReg <= 1'b0;
            testModeReg <= 1'b0;
            tckPrevReg <= 1'b0;
            tmsCntReg <= '0;
        end else begin
            stateReg <= stateNext;
            irShiftReg <= irShiftNext;
            irReg <= irNext;
            bypassReg <= bypassNext;
            idShiftReg <= idShiftNext;
            tdoReg <= tdoNext;
            tdoOeReg <= tdoOeNext;
            clampReg <= clampNext;
            testModeReg <= testModeNext;
            tckPrevReg <= tckPrevNext;
            tmsCntReg <= tmsCntNext;
        end
    end

    assign tdo = tdoReg;
    assign tdoOe = tdoOeReg;
    assign clampActive = clampReg;
    assign testModeActive = testModeReg;
    assign instrCurrent = irReg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_BYP_SHIFT: assert property (@(posedge clk) disable iff (rst) // RL1
        (pins.trstN && tckRise && stateReg == jtbi_pkg::SHIFT_DR && !idSel)
        |=> (bypassReg == $past(pins.tdi)))
        else $error("Bypass did not take TDI");

    AST_BYP_CAPTURE: assert property (@(posedge clk) disable iff (rst) // RL2
        (pins.trstN && tckRise && stateReg == jtbi_pkg::CAPTURE_DR && !idSel)
        |=> (bypassReg == `JTBI_BYPASS_CAPTURE))
        else $error("Bypass capture not zero");

    AST_CLAMP_PATH: assert property (@(posedge clk) disable iff (rst) // RL3
        (irReg == `JTBI_OP_CLAMP) |-> (clampActive && !idSel))
        else $error("Clamp not active or path wrong");

    AST_TRST_ID: assert property (@(posedge clk) disable iff (rst) // RL4
        !pins.trstN |=> (stateReg == jtbi_pkg::TEST_LOGIC_RESET && irReg == `JTBI_OP_IDCODE))
        else $error("Test reset did not select identification");

    AST_TMS_FIVE: assert property (@(posedge clk) disable iff (rst) // RL4
        (tmsCntReg == `JTBI_TMS_RESET_CNT) |-> (stateReg == jtbi_pkg::TEST_LOGIC_RESET))
        else $error("Five TMS-high clocks did not reset");

    AST_ID_CAPTURE: assert property (@(posedge clk) disable iff (rst) // RL9
        (pins.trstN && tckRise && stateReg == jtbi_pkg::CAPTURE_DR && idSel)
        |=> (idShiftReg == ID_VALUE && idShiftReg[0] == `JTBI_ID_LSB_VAL))
        else $error("Identification capture wrong");

    AST_RESET_DEFAULT: assert property (@(posedge clk) disable iff (rst) // RL7
        (stateReg == jtbi_pkg::TEST_LOGIC_RESET) |=> idSel)
        else $error("Bypass selected after reset");

    AST_ID_SHIFT: assert property (@(posedge clk) disable iff (rst) // RL8
        (pins.trstN && tckRise && stateReg == jtbi_pkg::SHIFT_DR && idSel)
        |=> (idShiftReg == {$past(pins.tdi), $past(idShiftReg[`JTBI_ID_W-1:1])}))
        else $error("Identification shift wrong");

    AST_IR_CAPTURE: assert property (@(posedge clk) disable iff (rst) // RL11
        (pins.trstN && tckRise && stateReg == jtbi_pkg::CAPTURE_IR)
        |=> (irShiftReg == `JTBI_OP_VALIDATE))
        else $error("Validate pattern not captured");

    AST_IR_HOLD: assert property (@(posedge clk) disable iff (rst) // RL15
        (pins.trstN && stateReg != jtbi_pkg::TEST_LOGIC_RESET &&
         !(tckFall && stateReg == jtbi_pkg::UPDATE_IR)) |=> (irReg == $past(irReg)))
        else $error("Instruction changed outside update");

    AST_TDO_FALL: assert property (@(posedge clk) disable iff (rst) // RL16
        (pins.trstN && tckFall && stateReg == jtbi_pkg::SHIFT_DR && !idSel)
        |=> (tdoOe && tdo == $past(bypassReg)))
        else $error("TDO not driven from bypass");

endmodule : jtbi_tap

`default_nettype wire

// *** verif/jtbi_tap_tb.sv ***
`include "jtbi_defs.svh"
`default_nettype none

module jtbi_tap_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitrary value
    localparam logic [10:0] MAKER = 11'h2a6;
    // Arbitrary value
    localparam logic [15:0] PART = 16'h5a3c;
    // Arbitrary value
    localparam logic [3:0] REV = 4'h9;
    localparam logic [31:0] ID_EXP = {REV, PART, MAKER, `JTBI_ID_LSB_VAL};
    localparam logic [7:0] PAT = 8'ha5;
    localparam logic [31:0] BYP_EXP = {24'h0, PAT[6:0], `JTBI_BYPASS_CAPTURE};

    logic clk = 1'b0;
    logic rst = 1'b1;
    jtbi_pkg::jtbi_pins_t pins;
    logic tdo;
    logic tdoOe;
    logic clampActive;
    logic testModeActive;
    logic [5:0] instrCurrent;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    jtbi_tap #(.MAKER_CODE_FIELD(MAKER), .PART_CODE(PART), .REVISION_CODE(REV)) dut (
        .clk(clk),
        .rst(rst),
        .pinsIn(pins),
        .tdo(tdo),
        .tdoOe(tdoOe),
        .clampActive(clampActive),
        .testModeActive(testModeActive),
        .instrCurrent(instrCurrent)
    );

    jtbi_tester tester (
        .clk(clk),
        .tdo(tdo),
        .tdoOe(tdoOe),
        .pins(pins)
    );

    // ------------------------------------------------------------
    // Checking and verdict
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // Ceiling a few times the roughly 1600 clk that the tests take
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic ok;
        int k;
        logic [5:0] ops [8];
        logic [7:0] rsvExp;
        ops = '{6'h3f, 6'h03, 6'h04, 6'h2c, 6'h2d, 6'h2e, 6'h3d, 6'h3e};
        rsvExp = 8'b0110_1100;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        tester.trstPulse();
        chk(instrCurrent, `JTBI_OP_IDCODE, "id after trst");
        chk(tdoOe, 1'b0, "oe idle");
        tester.scan(1'b0, 32, 32'h0, d, ok);
        chk(d, ID_EXP, "id value");
        chk(d[0], 1'b1, "id first bit");
        chk(ok, 1'b1, "oe in shift");
        tester.scan(1'b1, 6, `JTBI_OP_BYPASS, d, ok);
        chk(d[5:0], `JTBI_OP_VALIDATE, "ir capture");
        chk(d[1:0], 2'b01, "ir low bits");
        chk(instrCurrent, `JTBI_OP_BYPASS, "bypass current");
        tester.scan(1'b0, 8, PAT, d, ok);
        chk(d, BYP_EXP, "bypass path");
        tester.tmsReset();
        chk(instrCurrent, `JTBI_OP_IDCODE, "id after tms");
        tester.scan(1'b1, 6, `JTBI_OP_CLAMP, d, ok);
        chk(clampActive, 1'b1, "clamp level");
        tester.scan(1'b0, 8, PAT, d, ok);
        chk(d, BYP_EXP, "clamp path");
        for (k = 0; k < 8; k++) begin
            tester.scan(1'b1, 6, ops[k], d, ok);
            chk(instrCurrent, ops[k], "op current");
            chk(testModeActive, rsvExp[k], "reserved decode");
            chk(clampActive, ops[k] === `JTBI_OP_CLAMP, "clamp decode");
        end
        tester.trstPulse();
        chk(instrCurrent, `JTBI_OP_IDCODE, "id after mid trst");
        chk(clampActive, 1'b0, "clamp off");
        tester.scan(1'b0, 1, 32'h0, d, ok);
        chk(d[0], 1'b1, "first bit after trst");
        final_report();
    end

endmodule : jtbi_tap_tb

`default_nettype wire

// *** verif/jtbi_tester.sv ***
`default_nettype none

module jtbi_tester (
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdoOe,
    output jtbi_pkg::jtbi_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Idle state of the pins
    // ------------------------------------------------------------
    // hold in reset
    initial begin
        pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trstN: 1'b0};
    end

    // ------------------------------------------------------------
    // One tck period
    // ------------------------------------------------------------
    // Pins move only at the fall, so tms and tdi stand 4 clk either side of the rise
    task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
        pins.tms = tmsV;
        pins.tdi = tdiV;
        pins.tck = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        tdoV = tdo;
        pins.tck = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask : step

    // ------------------------------------------------------------
    // Scans and resets
    // ------------------------------------------------------------
    // reserved codes only on request
    task automatic scan(input logic ir, input int n, input logic [31:0] dIn,
                        output logic [31:0] dOut, output logic oeOk);
        logic b;
        int i;
        step(1'b1, 1'b1, b);
        if (ir) begin
            step(1'b1, 1'b1, b);
        end
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        dOut = '0;
        oeOk = 1'b1;
        for (i = 0; i < n; i++) begin
            step(i == n - 1, dIn[i], b);
            dOut[i] = b;
            oeOk = oeOk & (tdoOe === 1'b1);
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask : scan

    task automatic tmsReset();
        logic b;
        int i;
        for (i = 0; i < 5; i++) begin
            step(1'b1, 1'b1, b);
        end
        step(1'b0, 1'b1, b);
    endtask : tmsReset

    task automatic trstPulse();
        logic b;
        pins.trstN = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        pins.trstN = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        step(1'b0, 1'b1, b);
    endtask : trstPulse

endmodule : jtbi_tester

`default_nettype wire
